/* src/fswd_pkg.sv */
// package of constants and types for the flash settings write decoder
// assumes a byte-serial report source and a flash writer that handshakes
// Summary of operation
// - byte one selects target structure to store
// - unknown sub-code: no write, unsupported status
// - bytes two to sixtythree are payload
// - byte2 bit7 enables serial number descriptor
// - byte2 bit6 idle level, receive activity indicator
// - byte2 bit5 idle level, transmit activity indicator
// - byte2 bit4 idle level, i2c traffic indicator
// - byte2 bit3 suspend indicator level, inverted suspended
// - byte2 bit2 configured indicator, inverted once configured
// - byte2 bits1-0 select configuration security mode
// - byte3 bits4-0 divide 48 MHz reference clock
// - byte4 bits7-6 select converter reference level
// - byte4 bit5 selects supply or internal reference
// - byte4 bits4-0 converter power-up code
// - byte5 bits6,5 enable falling, rising edge detect
// - bytes6-9 vendor and product identifiers, low first
// - bytes12-19 hold eight-byte password
package fswd_pkg;
    localparam logic [7:0] FSWD_CMD_WRITE     = 8'hb1;
    localparam logic [7:0] FSWD_SUB_CHIP      = 8'h00;
    localparam logic [7:0] FSWD_SUB_PIN       = 8'h01;
    localparam logic [7:0] FSWD_SUB_MFG       = 8'h02;
    localparam logic [7:0] FSWD_SUB_PROD      = 8'h03;
    localparam logic [7:0] FSWD_SUB_SERIAL    = 8'h04;
    localparam logic [7:0] FSWD_STS_OK        = 8'h00;
    localparam logic [7:0] FSWD_STS_UNSUP     = 8'h02; // unsupported-command code
    localparam logic [5:0] FSWD_IDX_CMD       = 6'h00;
    localparam logic [5:0] FSWD_IDX_SUB       = 6'h01;
    localparam logic [5:0] FSWD_IDX_FLAGS     = 6'h02;
    localparam logic [5:0] FSWD_IDX_CLKDIV    = 6'h03;
    localparam logic [5:0] FSWD_IDX_DAC       = 6'h04;
    localparam logic [5:0] FSWD_IDX_EDGE      = 6'h05;
    localparam logic [5:0] FSWD_IDX_VID_LO    = 6'h06;
    localparam logic [5:0] FSWD_IDX_VID_HI    = 6'h07;
    localparam logic [5:0] FSWD_IDX_PID_LO    = 6'h08;
    localparam logic [5:0] FSWD_IDX_PID_HI    = 6'h09;
    localparam logic [5:0] FSWD_IDX_PW_FIRST  = 6'h0c;
    localparam logic [5:0] FSWD_IDX_PW_LAST   = 6'h13;
    localparam logic [5:0] FSWD_IDX_LAST      = 6'h3f;
    localparam int         FSWD_BIT_SERIAL    = 7;
    localparam int         FSWD_BIT_RX_IDLE   = 6;
    localparam int         FSWD_BIT_TX_IDLE   = 5;
    localparam int         FSWD_BIT_I2C_IDLE  = 4;
    localparam int         FSWD_BIT_SSP_IDLE  = 3;
    localparam int         FSWD_BIT_CFG_IDLE  = 2;
    localparam int         FSWD_BIT_DACSRC    = 5;
    localparam int         FSWD_BIT_NEG_EDGE  = 6;
    localparam int         FSWD_BIT_POS_EDGE  = 5;
    localparam logic [1:0] FSWD_SEC_OPEN      = 2'h0;
    localparam logic [1:0] FSWD_SEC_PASSWORD  = 2'h1;
    // reset values of the stored settings
    localparam logic [7:0] FSWD_RST_FLAGS     = 8'h00;
    localparam logic [4:0] FSWD_RST_CLKDIV    = 5'h00;
    localparam logic [7:0] FSWD_RST_DAC       = 8'h00;

    // decoded chip settings image
    typedef struct packed {
        logic        serial_enable;
        logic        rx_idle;
        logic        tx_idle;
        logic        i2c_idle;
        logic        ssp_idle;
        logic        cfg_idle;
        logic [1:0]  security;
        logic [4:0]  clk_div;
        logic [1:0]  dac_ref_level;
        logic        dac_ref_supply;
        logic [4:0]  dac_code;
        logic        neg_edge_en;
        logic        pos_edge_en;
        logic [15:0] vid;
        logic [15:0] pid;
        logic [63:0] password;
    } fswd_chip_s;

    // indicator activity inputs
    typedef struct packed {
        logic rx_busy;
        logic tx_busy;
        logic i2c_busy;
        logic suspended;
        logic configured;
    } fswd_act_s;

    // indicator pin levels
    typedef struct packed {
        logic rx;
        logic tx;
        logic i2c;
        logic ssp;
        logic cfg;
    } fswd_ind_s;
endpackage

/* src/fswd_indicators.sv */
// indicator pin drivers: idle level from settings, inverted while active
// assumes activity inputs are already synchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
module fswd_indicators
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // settings and activity
    input  wire fswd_pkg::fswd_chip_s cfg,
    input  wire fswd_pkg::fswd_act_s  act,
    // registered pin levels
    output var  fswd_pkg::fswd_ind_s  ind
);
    import fswd_pkg::*;

    // each pin shows its idle level, negated while its event is active
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ind <= '0;
        end
        else
        begin
            ind.rx  <= cfg.rx_idle  ^ act.rx_busy;
            ind.tx  <= cfg.tx_idle  ^ act.tx_busy;
            ind.i2c <= cfg.i2c_idle ^ act.i2c_busy;
            ind.ssp <= cfg.ssp_idle ^ act.suspended;
            ind.cfg <= cfg.cfg_idle ^ act.configured;
        end
    end
endmodule // fswd_indicators
`default_nettype wire

/* src/fswd_top.sv */
// flash settings write decoder: takes a 64-byte report one byte per beat,
// checks the command, decodes chip settings and issues a flash store request
// assumes report bytes arrive in index order, first marked by rpt_first
`timescale 1ns/1ns
`default_nettype none
module fswd_top
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // report byte stream
    input  wire logic              rpt_valid,
    input  wire logic              rpt_first,
    input  wire logic [7:0]        rpt_data,
    // activity inputs for indicator pins (synchronous)
    input  wire logic              uart_rx_busy,
    input  wire logic              uart_tx_busy,
    input  wire logic              i2c_busy,
    input  wire logic              usb_suspended,
    input  wire logic              usb_configured,
    // flash writer handshake
    input  wire logic              flash_done,
    output logic                   flash_req,
    output logic [7:0]             flash_target,
    output logic                   flash_bad_cmd,
    // response report
    output logic                   resp_valid,
    output logic [7:0]             resp_cmd,
    output logic [7:0]             resp_status,
    // decoded settings
    output fswd_pkg::fswd_chip_s   chip_cfg,
    // reference clock output divided from 48 MHz enable
    input  wire logic              clk48_tick,
    output logic                   ref_clk_out,
    // indicator pins
    output logic                   uart_receive_activity_indicator,
    output logic                   uart_transmit_activity_indicator,
    output logic                   i2c_traffic_indicator,
    output logic                   suspend_indicator,
    output logic                   usb_configured_indicator
);
    import fswd_pkg::*;

    typedef enum logic [1:0] {FSWD_IDLE, FSWD_RECV, FSWD_STORE} fswd_state_e;

    fswd_state_e state_q;          // report handling phase
    logic [5:0]  idx_q;            // index of next expected byte
    logic [7:0]  cmd_q;            // captured command byte
    logic [7:0]  sub_q;            // captured sub-code
    fswd_chip_s  shadow_q;         // chip settings being assembled
    logic        last_beat;        // final byte of the report
    logic        sub_known;        // sub-code is one of the five targets
    logic [4:0]  div_cnt_q;        // reference clock divider counter
    fswd_ind_s   ind;              // indicator pin levels
    fswd_act_s   act;              // bundled activity

    assign last_beat = rpt_valid && (idx_q == FSWD_IDX_LAST);
    assign sub_known = (sub_q <= FSWD_SUB_SERIAL);
    assign act       = '{rx_busy: uart_rx_busy, tx_busy: uart_tx_busy,
                         i2c_busy: i2c_busy, suspended: usb_suspended,
                         configured: usb_configured};

    // byte index tracking; rpt_first restarts the index at any time, but only in FSWD_IDLE does it open a new report
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            idx_q <= '0;
        end
        else if (rpt_valid && rpt_first)
        begin
            idx_q <= 6'h01;
        end
        else if (rpt_valid && state_q == FSWD_RECV)
        begin
            idx_q <= idx_q + 6'h01;
        end
    end

    // phase control: wait for a report, collect it, wait for flash
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= FSWD_IDLE;
        end
        else
        begin
            unique case (state_q)
                FSWD_IDLE:
                begin
                    // only the write-flash code opens a report here
                    if (rpt_valid && rpt_first && rpt_data == FSWD_CMD_WRITE)
                    begin
                        state_q <= FSWD_RECV;
                    end
                end
                FSWD_RECV:
                begin
                    if (last_beat)
                    begin
                        state_q <= FSWD_STORE;
                    end
                end
                FSWD_STORE:
                begin
                    // unknown targets never wait on the flash writer
                    if (flash_done || !sub_known)
                    begin
                        state_q <= FSWD_IDLE;
                    end
                end
                default:
                begin
                    state_q <= FSWD_IDLE;
                end
            endcase
        end
    end

    // capture command and sub-code
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_q <= '0;
            sub_q <= '0;
        end
        else if (rpt_valid && rpt_first)
        begin
            cmd_q <= rpt_data;
        end
        else if (rpt_valid && state_q == FSWD_RECV && idx_q == FSWD_IDX_SUB)
        begin
            sub_q <= rpt_data;
        end
    end

    // payload unpacking for the chip settings layout
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            shadow_q <= '0;
        end
        else if (rpt_valid && state_q == FSWD_RECV && sub_q == FSWD_SUB_CHIP)
        begin
            // unlisted indices and bits are simply not captured
            unique case (idx_q)
                FSWD_IDX_FLAGS:
                begin
                    shadow_q.serial_enable <= rpt_data[FSWD_BIT_SERIAL];
                    shadow_q.rx_idle       <= rpt_data[FSWD_BIT_RX_IDLE];
                    shadow_q.tx_idle       <= rpt_data[FSWD_BIT_TX_IDLE];
                    shadow_q.i2c_idle      <= rpt_data[FSWD_BIT_I2C_IDLE];
                    shadow_q.ssp_idle      <= rpt_data[FSWD_BIT_SSP_IDLE];
                    shadow_q.cfg_idle      <= rpt_data[FSWD_BIT_CFG_IDLE];
                    shadow_q.security      <= rpt_data[1:0];
                end
                FSWD_IDX_CLKDIV:
                begin
                    shadow_q.clk_div <= rpt_data[4:0];
                end
                FSWD_IDX_DAC:
                begin
                    shadow_q.dac_ref_level  <= rpt_data[7:6];
                    shadow_q.dac_ref_supply <= rpt_data[FSWD_BIT_DACSRC];
                    shadow_q.dac_code       <= rpt_data[4:0];
                end
                FSWD_IDX_EDGE:
                begin
                    shadow_q.neg_edge_en <= rpt_data[FSWD_BIT_NEG_EDGE];
                    shadow_q.pos_edge_en <= rpt_data[FSWD_BIT_POS_EDGE];
                end
                FSWD_IDX_VID_LO: shadow_q.vid[7:0]  <= rpt_data;
                FSWD_IDX_VID_HI: shadow_q.vid[15:8] <= rpt_data;
                FSWD_IDX_PID_LO: shadow_q.pid[7:0]  <= rpt_data;
                FSWD_IDX_PID_HI: shadow_q.pid[15:8] <= rpt_data;
                default:
                begin
                    // password bytes land in order, first byte lowest
                    if (idx_q >= FSWD_IDX_PW_FIRST && idx_q <= FSWD_IDX_PW_LAST)
                    begin
                        shadow_q.password <= {rpt_data, shadow_q.password[63:8]};
                    end
                end
            endcase
        end
    end

    // settings take effect only once the whole report is in, so a torn
    // report never leaves half-updated levels on the pins
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            chip_cfg <= '0;
        end
        else if (state_q == FSWD_STORE && sub_q == FSWD_SUB_CHIP && flash_done)
        begin
            chip_cfg <= shadow_q;
        end
    end

    // flash store request, held until the writer answers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            flash_req     <= 1'b0;
            flash_target  <= '0;
            flash_bad_cmd <= 1'b0;
        end
        else
        begin
            flash_bad_cmd <= 1'b0;
            if (last_beat && state_q == FSWD_RECV)
            begin
                flash_target <= sub_q;
                if (sub_known)
                begin
                    flash_req <= 1'b1;
                end
                else
                begin
                    flash_bad_cmd <= 1'b1;
                end
            end
            else if (flash_done)
            begin
                flash_req <= 1'b0;
            end
        end
    end

    // response report: command echo plus completion status, one cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            resp_valid  <= 1'b0;
            resp_cmd    <= '0;
            resp_status <= '0;
        end
        else
        begin
            resp_valid <= 1'b0;
            if (state_q == FSWD_STORE && (flash_done || !sub_known))
            begin
                resp_valid  <= 1'b1;
                resp_cmd    <= cmd_q;
                resp_status <= sub_known ? FSWD_STS_OK : FSWD_STS_UNSUP;
            end
        end
    end

    // reference clock: toggles every clk_div+1 ticks of the 48 MHz enable
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_q   <= '0;
            ref_clk_out <= 1'b0;
        end
        else if (clk48_tick)
        begin
            if (div_cnt_q >= chip_cfg.clk_div)
            begin
                div_cnt_q   <= '0;
                ref_clk_out <= ~ref_clk_out;
            end
            else
            begin
                div_cnt_q <= div_cnt_q + 5'h01;
            end
        end
    end

    // indicator pin drivers
    fswd_indicators fswd_indicators_i
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .cfg     (chip_cfg),
        .act     (act),
        .ind     (ind)
    );

    // pin outputs come straight from the indicator flip-flops
    assign uart_receive_activity_indicator  = ind.rx;
    assign uart_transmit_activity_indicator = ind.tx;
    assign i2c_traffic_indicator            = ind.i2c;
    assign suspend_indicator                = ind.ssp;
    assign usb_configured_indicator         = ind.cfg;
endmodule // fswd_top
`default_nettype wire

/* tb/fswd_props.sv */
// assertions on the ports of the flash settings write decoder
// assumes it is bound into fswd_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module fswd_props
    import fswd_pkg::*;
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // activity inputs
    input wire logic       uart_rx_busy,
    input wire logic       uart_tx_busy,
    input wire logic       i2c_busy,
    input wire logic       usb_suspended,
    input wire logic       usb_configured,
    // flash and response
    input wire logic       flash_done,
    input wire logic       flash_req,
    input wire logic [7:0] flash_target,
    input wire logic       flash_bad_cmd,
    input wire logic       resp_valid,
    input wire logic [7:0] resp_cmd,
    input wire logic [7:0] resp_status,
    input wire fswd_chip_s chip_cfg,
    // indicator pins
    input wire logic       uart_receive_activity_indicator,
    input wire logic       uart_transmit_activity_indicator,
    input wire logic       i2c_traffic_indicator,
    input wire logic       suspend_indicator,
    input wire logic       usb_configured_indicator
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // first edge after reset still holds reset levels, so skip it
    a_uart_ind_follow: assert property (
        !$past(rst) |->
        uart_receive_activity_indicator == $past(chip_cfg.rx_idle ^ uart_rx_busy) &&
        uart_transmit_activity_indicator == $past(chip_cfg.tx_idle ^ uart_tx_busy))
        else $error("uart indicator level wrong");
    a_status_ind_follow: assert property (
        !$past(rst) |->
        i2c_traffic_indicator == $past(chip_cfg.i2c_idle ^ i2c_busy) &&
        suspend_indicator == $past(chip_cfg.ssp_idle ^ usb_suspended) &&
        usb_configured_indicator == $past(chip_cfg.cfg_idle ^ usb_configured))
        else $error("status indicator level wrong");
    a_bad_unsup_resp: assert property (
        flash_bad_cmd |=> resp_valid && resp_cmd == FSWD_CMD_WRITE &&
        resp_status == FSWD_STS_UNSUP)
        else $error("unknown sub-code answer wrong");
    a_bad_no_store: assert property (
        flash_bad_cmd |-> !flash_req ##1 !flash_req)
        else $error("store issued for unknown sub-code");
    a_done_ok_resp: assert property (
        flash_req && flash_done |=> resp_valid && !flash_req &&
        resp_cmd == FSWD_CMD_WRITE && resp_status == FSWD_STS_OK)
        else $error("completion answer wrong");
    a_req_target_hold: assert property (
        flash_req && !flash_done |=> flash_req && $stable(flash_target))
        else $error("store request dropped or target moved");
    a_target_defined: assert property (
        flash_req |-> flash_target <= FSWD_SUB_SERIAL)
        else $error("store to undefined target");
    a_cfg_on_store: assert property (
        !$past(rst) && chip_cfg != $past(chip_cfg) |->
        resp_valid && $past(flash_target) == FSWD_SUB_CHIP)
        else $error("settings changed outside chip store");
    a_resp_cause: assert property (
        resp_valid |-> ($past(flash_done && flash_req) || $past(flash_bad_cmd))
        ##1 !resp_valid)
        else $error("response without cause or too long");
endmodule // fswd_props

bind fswd_top fswd_props fswd_props_i (.sys_clk, .rst, .uart_rx_busy, .uart_tx_busy,
    .i2c_busy, .usb_suspended, .usb_configured, .flash_done, .flash_req, .flash_target,
    .flash_bad_cmd, .resp_valid, .resp_cmd, .resp_status, .chip_cfg,
    .uart_receive_activity_indicator, .uart_transmit_activity_indicator,
    .i2c_traffic_indicator, .suspend_indicator, .usb_configured_indicator);
`default_nettype wire

/* tb/fswd_host_model.sv */
// host sending 64-byte reports plus the flash writer answering stores
// assumes the bench sets done_delay and calls send_report
`timescale 1ns/1ns
`default_nettype none
module fswd_host_model
(
    // clock
    input  wire logic       sys_clk,
    // report byte stream
    output logic            rpt_valid,
    output logic            rpt_first,
    output logic [7:0]      rpt_data,
    // flash writer handshake
    input  wire logic       flash_req,
    output logic            flash_done
);
    int done_delay = 0; // cycles the flash writer stalls
    int wait_cnt   = 0; // stall counter
    initial
    begin
        rpt_valid  = 1'b0;
        rpt_first  = 1'b0;
        rpt_data   = 8'h5a;
        flash_done = 1'b0;
    end

    // one byte per beat in index order, byte 0 flagged first
    task automatic send_report(input logic [7:0] r [64]);
        for (int i = 0; i < 64; i++)
        begin
            @(posedge sys_clk);
            #5;
            rpt_valid = 1'b1;
            rpt_first = (i == 0);
            rpt_data  = r[i];
        end
        @(posedge sys_clk);
        #5;
        rpt_valid = 1'b0;
        rpt_first = 1'b0;
        rpt_data  = ~rpt_data; // released: leave no stale byte
    endtask

    // flash writer: one-cycle done after done_delay stalled cycles
    always @(posedge sys_clk)
    begin
        #5;
        if (flash_done)
        begin
            flash_done = 1'b0;
            wait_cnt   = 0;
        end
        else if (flash_req)
        begin
            // count stalled cycles apart from the test, so any simulator takes it
            if (wait_cnt >= done_delay)
                flash_done = 1'b1;
            wait_cnt++;
        end
    end
endmodule // fswd_host_model
`default_nettype wire

/* tb/fswd_tb_top.sv */
// self-checking bench of the flash settings write decoder
// assumes the host model and the bound checker sit beside it
`timescale 1ns/1ns
`default_nettype none
module fswd_tb_top;
    import fswd_pkg::*;
    typedef struct packed { logic [7:0] st; fswd_chip_s cfg; } fswd_note_s;
    logic       sys_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       rpt_valid, rpt_first, flash_done, flash_req, flash_bad_cmd;
    logic [7:0] rpt_data, flash_target, resp_cmd, resp_status;
    logic       resp_valid, clk48_tick, ref_clk_out;
    logic       uart_rx_busy, uart_tx_busy, i2c_busy, usb_suspended, usb_configured;
    logic       ind_rx, ind_tx, ind_i2c, ind_ssp, ind_cfg;
    fswd_chip_s chip_cfg;
    fswd_chip_s cfg_exp;      // settings the design should hold
    fswd_note_s notes[$];     // expected responses, oldest first
    fswd_note_s note, nw;
    logic [7:0] rpt [64];
    logic [31:0] lfsr = 32'h76a3;
    int errors = 0, total_checks = 0, cycles = 0, resp_seen = 0;

    always #25 sys_clk = ~sys_clk;
    // 48 MHz enable on every other cycle, so the divider is seen to wait for it
    always @(posedge sys_clk) #5 clk48_tick = ~clk48_tick;

    fswd_top fswd_top_i (.sys_clk, .rst, .rpt_valid, .rpt_first, .rpt_data,
        .uart_rx_busy, .uart_tx_busy, .i2c_busy, .usb_suspended, .usb_configured,
        .flash_done, .flash_req, .flash_target, .flash_bad_cmd, .resp_valid,
        .resp_cmd, .resp_status, .chip_cfg, .clk48_tick, .ref_clk_out,
        .uart_receive_activity_indicator(ind_rx), .uart_transmit_activity_indicator(ind_tx),
        .i2c_traffic_indicator(ind_i2c), .suspend_indicator(ind_ssp),
        .usb_configured_indicator(ind_cfg));
    fswd_host_model host_i (.sys_clk, .rpt_valid, .rpt_first, .rpt_data, .flash_req,
        .flash_done);

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // field order follows the packed settings image, password byte 12 lowest
    function automatic fswd_chip_s decode(input logic [7:0] r [64]);
        return {r[2], r[3][4:0], r[4], r[5][6:5], r[7], r[6], r[9], r[8],
            r[19], r[18], r[17], r[16], r[15], r[14], r[13], r[12]};
    endfunction
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic fill_random;
        for (int i = 2; i < 64; i++)
        begin
            lfsr = lfsr_next(lfsr);
            rpt[i] = lfsr[7:0];
        end
    endtask
    // send one report, note the answer, watch the store handshake
    task automatic run_report(input logic [7:0] cmd, input logic [7:0] sub);
        int seen;
        rpt[0] = cmd;
        rpt[1] = sub;
        seen = resp_seen;
        if (cmd == FSWD_CMD_WRITE)
        begin
            if (sub == FSWD_SUB_CHIP)
                cfg_exp = decode(rpt);
            nw.st  = (sub <= FSWD_SUB_SERIAL) ? FSWD_STS_OK : FSWD_STS_UNSUP;
            nw.cfg = cfg_exp;
            notes.push_back(nw);
        end
        host_i.send_report(rpt);
        for (int i = 0; i < 300 && resp_seen == seen; i++)
        begin
            @(posedge sys_clk);
            #1;
            if (flash_req === 1'b1)
                check({cmd, flash_target}, {FSWD_CMD_WRITE, sub});
            if (flash_bad_cmd === 1'b1)
                check({cmd, sub > FSWD_SUB_SERIAL}, {FSWD_CMD_WRITE, 1'b1});
        end
        check(resp_seen - seen, cmd == FSWD_CMD_WRITE);
    endtask
    // indicators: idle level, inverted while active
    task automatic check_ind;
        for (int k = 0; k < 8; k++)
        begin
            lfsr = lfsr_next(lfsr);
            @(posedge sys_clk);
            #5;
            {uart_rx_busy, uart_tx_busy, i2c_busy, usb_suspended, usb_configured} = lfsr[4:0];
            repeat (2) @(posedge sys_clk);
            #1;
            check({ind_rx, ind_tx, ind_i2c, ind_ssp, ind_cfg},
                cfg_exp[117:113] ^ lfsr[4:0]);
        end
    endtask
    // first pass finds a toggle, second measures one half period
    task automatic check_refclk(input int div);
        int n;
        logic v;
        for (int p = 0; p < 2; p++)
        begin
            v = ref_clk_out;
            n = 0;
            while (ref_clk_out === v && n < 70)
            begin
                @(posedge sys_clk);
                #1;
                n++;
            end
        end
        check(n, 2 * (div + 1));
    endtask

    // monitor: each response is matched against the oldest note
    always @(posedge sys_clk)
    begin
        if (resp_valid === 1'b1)
        begin
            resp_seen++;
            if (notes.size() == 0)
                check(1, 0);
            else
            begin
                note = notes.pop_front();
                check(resp_cmd, FSWD_CMD_WRITE);
                check(resp_status, note.st);
                check(chip_cfg, note.cfg);
            end
        end
    end
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        {uart_rx_busy, uart_tx_busy, i2c_busy, usb_suspended, usb_configured} = 5'h00;
        clk48_tick = 1'b0;
        cfg_exp = '0;
        repeat (20) @(posedge sys_clk);
        #5;
        rst = 1'b0;
        // every defined target, flash answering prompt to slow
        for (int s = 0; s < 5; s++)
        begin
            host_i.done_delay = s * 7;
            fill_random();
            run_report(FSWD_CMD_WRITE, s[7:0]);
        end
        // every security and reference code, divider from 0 to 30
        for (int m = 0; m < 4; m++)
        begin
            fill_random();
            rpt[2][1:0] = m[1:0];
            rpt[4][7:5] = {m[1:0], m[0]};
            rpt[3] = {3'h7, 5'(m * 10)};
            run_report(FSWD_CMD_WRITE, FSWD_SUB_CHIP);
            check_ind();
            check_refclk(m * 10);
        end
        // unknown sub-codes, then a foreign command that must be ignored
        run_report(FSWD_CMD_WRITE, 8'h05);
        run_report(FSWD_CMD_WRITE, 8'hff);
        run_report(8'hb0, FSWD_SUB_CHIP);
        check(notes.size(), 0);
        tally_and_finish();
    end
endmodule // fswd_tb_top
`default_nettype wire
